/* File: hdl/pcs_fix.sv */
// Intentionally empty: the sequencer keeps all of its logic in one file

/* File: hdl/pcs_pkg.sv */
// Constants, register map and state type of the peripheral command sequencer
package pcs_pkg;
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFF_ARG  = 5'h00;
    localparam logic [4:0] OFF_OP   = 5'h04;
    localparam logic [4:0] OFF_OUT  = 5'h08;
    localparam logic [4:0] OFF_CODE = 5'h0c;
    localparam logic [4:0] OFF_IN   = 5'h10;
    localparam logic [4:0] OFF_STAT = 5'h14;
    localparam logic [4:0] OFF_FLAG = 5'h18;
    localparam logic [2:0] OP_TEXT  = 3'h1;
    localparam logic [2:0] OP_IMG   = 3'h2;
    localparam logic [2:0] OP_PUNCH = 3'h3;
    localparam logic [2:0] OP_DRW   = 3'h4;
    localparam logic [2:0] OP_DRR   = 3'h5;
    localparam logic [2:0] OP_MSG   = 3'h6;
    localparam logic [2:0] C_LIM    = 3'h4;
    localparam logic [2:0] C_P1     = 3'h1;
    localparam logic [2:0] C_P2     = 3'h2;
    localparam logic [2:0] C_P3     = 3'h3;
    localparam logic [2:0] C_M1     = 3'h5;
    localparam logic [2:0] C_M2     = 3'h6;
    localparam int WORD_W  = 30;
    localparam int COL_W   = 12;
    localparam int ROW_W   = 80;
    localparam int LAST_W  = 20;
    localparam int TS_W    = 15;
    localparam int DEST_W  = 8;
    localparam int HI_LSB  = 18;
    localparam int MID_LSB = 6;
    localparam int LO_W    = 6;
    localparam int P2_LSB  = 30;
    localparam int P3_LSB  = 60;
    localparam logic [2:0] TEXT_LAST = 3'h4;
    localparam logic [2:0] IMG_LAST  = 3'h2;
    localparam logic [4:0] TEXT_WORDS = 5'h10;
    localparam logic [4:0] IMG_WORDS  = 5'h1b;
    localparam logic [4:0] DRUM_LAST  = 5'h1e;
    localparam int ST_DERR = 0;
    localparam int ST_TERR = 1;
    localparam int ST_EOF  = 2;
    localparam int ST_BUSY = 3;
    localparam int ST_FLAG = 4;
    localparam int ST_DONE = 5;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [5:0] {
        S_CLAIMED = 6'h01,
        S_CARD    = 6'h02,
        S_PUNCH   = 6'h04,
        S_DRW     = 6'h08,
        S_DRR     = 6'h10,
        S_MSG     = 6'h20
    } pcs_state_t;
endpackage : pcs_pkg

/* File: hdl/pcs_sequencer.sv */
// Peripheral command sequencer with AXI4-Lite register access
`timescale 1ns/1ps
module pcs_sequencer #(
    parameter int RESP_CYCLES = 64
) (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic [pcs_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                       awvalid,
    output logic                            awready,
    input  wire logic [31:0]                wdata,
    input  wire logic [3:0]                 wstrb,
    input  wire logic                       wvalid,
    output logic                            wready,
    output logic [1:0]                      bresp,
    output logic                            bvalid,
    input  wire logic                       bready,
    input  wire logic [pcs_pkg::ADDR_W-1:0] araddr,
    input  wire logic                       arvalid,
    output logic                            arready,
    output logic [31:0]                     rdata,
    output logic [1:0]                      rresp,
    output logic                            rvalid,
    input  wire logic                       rready,
    output logic                            command_accept_pulse,
    output logic                            priority_flag,
    output logic                            call_back,
    output logic                            reader_run,
    input  wire logic                       card_col_valid,
    input  wire logic [pcs_pkg::COL_W-1:0]  card_col,
    input  wire logic                       card_end,
    input  wire logic                       hopper_empty,
    output logic                            punch_run,
    input  wire logic                       punch_row_req,
    input  wire logic                       punch_last_row,
    output logic                            punch_fire,
    output logic [pcs_pkg::ROW_W-1:0]       punch_row,
    output logic                            drum_run,
    output logic [pcs_pkg::TS_W-1:0]        drum_track_sector,
    input  wire logic                       drum_bit_tick,
    output logic                            drum_wbit,
    output logic                            drum_wen,
    input  wire logic                       drum_rbit,
    input  wire logic                       drum_block_end,
    output logic [pcs_pkg::WORD_W-1:0]      trunk_word,
    output logic                            trunk_valid,
    output logic                            trunk_eom,
    output logic [pcs_pkg::DEST_W-1:0]      trunk_addressees,
    input  wire logic [pcs_pkg::DEST_W-1:0] trunk_ack,
    input  wire logic                       trunk_lockout
);
    import pcs_pkg::*;

    // Hollerith column to {invalid, zone, digit}; two or more zone punches, or two or more digit punches, are invalid
    function automatic logic [6:0] col_char(input logic [COL_W-1:0] c);
        logic [3:0] dig;
        logic [1:0] zon;
        dig = 4'h0;
        for (int i = 0; i < 9; i++) begin
            if (c[8-i]) dig = 4'(i + 1);
        end
        zon = c[11] ? 2'h3 : c[10] ? 2'h2 : c[9] ? 2'h1 : 2'h0;
        col_char = {($countones(c[11:9]) > 1) || ($countones(c[8:0]) > 1), zon, dig};
    endfunction : col_char

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
        merge = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) merge[b*8 +: 8] = n[b*8 +: 8];
        end
    endfunction : merge

    pcs_state_t state_q;
    logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q, rdata_q, arg_q;
    logic [3:0] w_strb_q;
    logic [1:0] bresp_q, rresp_q;
    logic [2:0] code_q, cnt_q;
    logic [4:0] words_q, bit_q;
    logic img_q, done_q, flag_q, accept_q, cb_q, derr_q, terr_q, eof_q;
    logic [WORD_W-1:0] acc_q, din_q, dw_word_q;
    logic [ROW_W-1:0] row_q;
    logic row_ready_q, dw_have_q, clear_q, abandon_q, eom_q;
    logic [WORD_W:0] sh_q;
    logic [DEST_W-1:0] acked_q;
    logic [15:0] timer_q;

    // Register bus decode
    wire wr_fire = aw_have_q && w_have_q && !bvalid_q;
    wire rd_fire = arvalid && !rvalid_q;
    wire wr_map = aw_addr_q <= OFF_FLAG && aw_addr_q[1:0] == 2'h0;
    wire rd_map = araddr <= OFF_FLAG && araddr[1:0] == 2'h0;
    wire cmd_wr = wr_fire && aw_addr_q == OFF_OP;
    wire out_wr = wr_fire && aw_addr_q == OFF_OUT;
    wire flag_wr = wr_fire && aw_addr_q == OFF_FLAG;
    wire in_rd = rd_fire && araddr == OFF_IN;
    wire [2:0] op = w_data_q[2:0];
    wire op_ok = op >= OP_TEXT && op <= OP_MSG;
    wire [WORD_W-1:0] out_word = w_data_q[WORD_W-1:0];
    wire last_code = code_q < C_LIM;

    wire st_clm = state_q == S_CLAIMED;
    wire st_card = state_q == S_CARD;
    wire st_pun = state_q == S_PUNCH;
    wire st_dw = state_q == S_DRW;
    wire st_dr = state_q == S_DRR;
    wire st_msg = state_q == S_MSG;

    wire accept = cmd_wr && st_clm && op_ok && !(op == OP_MSG && trunk_lockout);
    wire ds_xfer = (in_rd || out_wr) && st_clm && done_q;
    wire eom_wr = out_wr && st_msg && last_code;

    // Card side
    wire [6:0] chr = col_char(card_col);
    wire [2:0] grp_last = img_q ? IMG_LAST : TEXT_LAST;
    wire [4:0] word_lim = img_q ? IMG_WORDS : TEXT_WORDS;
    wire col_ev = st_card && card_col_valid && words_q < word_lim;
    wire card_word_ev = col_ev && cnt_q == grp_last;
    wire card_flush = st_card && card_end && img_q && cnt_q != 3'h0 && words_q < word_lim;
    wire card_done = st_card && card_end;

    // Punch side
    wire pun_more = st_pun && out_wr && !last_code;
    wire pun_req = st_pun && punch_row_req;
    wire pun_done = pun_req && punch_last_row;

    // Drum side
    wire load_ev = st_dw && drum_bit_tick && bit_q == 5'h0 && dw_have_q;
    wire dr_word = st_dr && drum_bit_tick && !abandon_q && bit_q == DRUM_LAST;
    wire drum_done = (st_dw || st_dr) && drum_block_end;
    wire timeout = flag_q && (st_dw || st_dr) && timer_q == 16'(RESP_CYCLES - 1);

    // Trunk side
    wire all_ack = trunk_valid && ((acked_q | trunk_ack) & trunk_addressees) == trunk_addressees;
    wire msg_done = st_msg && all_ack && eom_q;

    wire complete = card_done || pun_done || drum_done || msg_done;
    wire flag_set = card_word_ev || card_flush || complete || pun_more || (pun_req && !punch_last_row)
        || load_ev || dr_word || (accept && (op == OP_PUNCH || op == OP_DRW))
        || (flag_wr && st_msg) || (st_msg && all_ack && !eom_q);
    // A new demand outranks the transfer that answers the previous one
    wire flag_d = flag_set || (flag_q && !(in_rd || out_wr || timeout));

    wire [31:0] status = 32'({done_q, flag_q, !st_clm, eof_q, terr_q, derr_q});
    wire [31:0] in_val = (st_card || st_dr) ? 32'(din_q) : status;
    wire [31:0] rd_val = araddr == OFF_ARG ? arg_q : araddr == OFF_CODE ? 32'(code_q)
        : araddr == OFF_IN ? in_val : araddr == OFF_STAT ? status
        : araddr == OFF_FLAG ? 32'(flag_q) : 32'h0;

    assign awready = !aw_have_q && !bvalid_q;
    assign wready = !w_have_q && !bvalid_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = !rvalid_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign command_accept_pulse = accept_q;
    assign priority_flag = flag_q;
    assign call_back = cb_q;
    assign reader_run = st_card;
    assign punch_run = st_pun;
    assign drum_run = st_dw || st_dr;
    assign drum_track_sector = arg_q[TS_W-1:0];
    assign drum_wbit = sh_q[WORD_W];
    assign drum_wen = st_dw;
    assign trunk_addressees = arg_q[DEST_W:1];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b0;
            rvalid_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
            bresp_q <= RESP_OKAY;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0;
        end else begin
            if (awvalid && awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_have_q <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_map ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid_q <= 1'b0;
            end
            if (rd_fire) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_val;
                rresp_q <= rd_map ? RESP_OKAY : RESP_SLVERR;
            end else if (rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // Command control, flags and status
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= S_CLAIMED;
            arg_q <= 32'h0;
            code_q <= 3'h0;
            img_q <= 1'b0;
            done_q <= 1'b0;
            flag_q <= 1'b0;
            accept_q <= 1'b0;
            cb_q <= 1'b0;
            derr_q <= 1'b0;
            terr_q <= 1'b0;
            eof_q <= 1'b0;
            timer_q <= 16'h0;
        end else begin
            flag_q <= flag_d;
            accept_q <= accept || ds_xfer || eom_wr;
            cb_q <= complete;
            timer_q <= (flag_set || !flag_q) ? 16'h0 : timer_q + 16'h1;
            if (wr_fire && aw_addr_q == OFF_ARG && st_clm) arg_q <= merge(arg_q, w_data_q, w_strb_q);
            if (wr_fire && aw_addr_q == OFF_CODE) code_q <= w_data_q[2:0];
            if (accept) begin
                done_q <= 1'b0;
                derr_q <= 1'b0;
                terr_q <= 1'b0;
                eof_q <= 1'b0;
                img_q <= op == OP_IMG;
                case (op)
                    OP_TEXT, OP_IMG: state_q <= S_CARD;
                    OP_PUNCH: state_q <= S_PUNCH;
                    OP_DRW: state_q <= S_DRW;
                    OP_DRR: state_q <= S_DRR;
                    OP_MSG: state_q <= S_MSG;
                    default: state_q <= S_CLAIMED;
                endcase
            end else if (complete) begin
                state_q <= S_CLAIMED;
                done_q <= 1'b1;
            end
            if (col_ev && (img_q ? (cnt_q == IMG_LAST && |card_col[LO_W-1:0]) : chr[6])) derr_q <= 1'b1;
            if (dr_word && !(^{sh_q[WORD_W-1:0], drum_rbit})) derr_q <= 1'b1;
            if ((pun_req && !row_ready_q) || timeout) terr_q <= 1'b1;
            if (st_card && hopper_empty) eof_q <= 1'b1;
        end
    end

    // Card assembly and punch row buffer
    always_ff @(posedge aclk) begin
        if (!aresetn || accept) begin
            cnt_q <= 3'h0;
            words_q <= 5'h0;
            acc_q <= '0;
            din_q <= '0;
            row_q <= '0;
            row_ready_q <= 1'b0;
            punch_fire <= 1'b0;
            punch_row <= '0;
        end else begin
            punch_fire <= pun_req;
            if (col_ev) begin
                cnt_q <= cnt_q == grp_last ? 3'h0 : cnt_q + 3'h1;
                if (!img_q) acc_q <= {acc_q[WORD_W-7:0], chr[5:0]};
                else if (cnt_q == 3'h0) acc_q <= {card_col, HI_LSB'(0)};
                else if (cnt_q == 3'h1) acc_q[HI_LSB-1:MID_LSB] <= card_col;
                else acc_q[LO_W-1:0] <= card_col[COL_W-1:COL_W-LO_W];
            end
            if (card_word_ev || card_flush) words_q <= words_q + 5'h1;
            if (card_word_ev) din_q <= img_q ? {acc_q[WORD_W-1:LO_W], card_col[COL_W-1:COL_W-LO_W]}
                : {acc_q[WORD_W-7:0], chr[5:0]};
            else if (card_flush) din_q <= acc_q;
            else if (dr_word) din_q <= sh_q[WORD_W-1:0];
            if (pun_req) begin
                punch_row <= row_q;
                row_q <= '0;
                row_ready_q <= 1'b0;
            end
            // Data landing with the punch strobe belongs to the next row
            if (st_pun && out_wr) begin
                case (code_q)
                    C_P1, C_M1: row_q[WORD_W-1:0] <= out_word;
                    C_P2, C_M2: row_q[P2_LSB +: WORD_W] <= out_word;
                    C_P3: row_q[P3_LSB +: LAST_W] <= out_word[LAST_W-1:0];
                    default: ;
                endcase
                if (last_code) row_ready_q <= 1'b1;
            end
        end
    end

    // Drum serial path and message trunk
    always_ff @(posedge aclk) begin
        if (!aresetn || accept) begin
            bit_q <= 5'h0;
            sh_q <= '0;
            dw_word_q <= '0;
            dw_have_q <= 1'b0;
            clear_q <= 1'b0;
            abandon_q <= 1'b0;
            trunk_word <= '0;
            trunk_valid <= 1'b0;
            trunk_eom <= 1'b0;
            eom_q <= 1'b0;
            acked_q <= '0;
        end else begin
            if (st_dw && out_wr && !clear_q) begin
                dw_word_q <= out_word;
                dw_have_q <= 1'b1;
                if (last_code) clear_q <= 1'b1;
            end
            if (timeout) begin
                clear_q <= st_dw;
                abandon_q <= st_dr;
            end
            if (st_dw && drum_bit_tick) begin
                bit_q <= bit_q == DRUM_LAST ? 5'h0 : bit_q + 5'h1;
                if (load_ev) begin
                    sh_q <= {dw_word_q, ~^dw_word_q};
                    dw_have_q <= 1'b0;
                end else if (bit_q == 5'h0) sh_q <= '0;
                else sh_q <= {sh_q[WORD_W-1:0], 1'b0};
            end
            if (st_dr && drum_bit_tick && !abandon_q) begin
                bit_q <= bit_q == DRUM_LAST ? 5'h0 : bit_q + 5'h1;
                sh_q <= {sh_q[WORD_W-1:0], drum_rbit};
            end
            acked_q <= trunk_valid ? acked_q | trunk_ack : '0;
            if (st_msg && out_wr) begin
                trunk_word <= out_word;
                trunk_valid <= 1'b1;
                trunk_eom <= last_code;
                eom_q <= last_code;
                acked_q <= '0;
            end else if (all_ack) trunk_valid <= 1'b0;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_done;
        state_q == S_CLAIMED && call_back && priority_flag;
    endsequence
    property p_busy_refuses; cmd_wr && !st_clm |=> !command_accept_pulse; endproperty
    a_busy_refuses: assert property (p_busy_refuses) else $error("command taken while busy");
    property p_accept; accept |=> command_accept_pulse && state_q != S_CLAIMED; endproperty
    a_accept: assert property (p_accept) else $error("accept without pulse or busy");
    property p_status_rd; in_rd && st_clm && done_q |=> command_accept_pulse && rvalid && rdata[ST_DONE]; endproperty
    a_status_rd: assert property (p_status_rd) else $error("status read wrong");
    property p_card_word; card_word_ev |=> priority_flag && words_q == $past(words_q) + 5'h1; endproperty
    a_card_word: assert property (p_card_word) else $error("card word not flagged");
    property p_card_end; card_done |=> s_done; endproperty
    a_card_end: assert property (p_card_end) else $error("card end not completed");
    property p_drop_err; col_ev && img_q && cnt_q == IMG_LAST && |card_col[LO_W-1:0] |=> status[ST_DERR]; endproperty
    a_drop_err: assert property (p_drop_err) else $error("dropped punch not flagged");
    property p_row_late; pun_req && !row_ready_q |=> status[ST_TERR] && punch_fire; endproperty
    a_row_late: assert property (p_row_late) else $error("late row not flagged");
    property p_punch_end; pun_done |=> s_done ##1 !call_back; endproperty
    a_punch_end: assert property (p_punch_end) else $error("punch end not completed");
    property p_parity; load_ev |=> ^sh_q; endproperty
    a_parity: assert property (p_parity) else $error("drum parity not odd");
    property p_timeout; timeout && !flag_set |=> status[ST_TERR] && !priority_flag && (clear_q || abandon_q); endproperty
    a_timeout: assert property (p_timeout) else $error("drum timeout not handled");
    property p_msg_end; msg_done |=> s_done or (state_q == S_CLAIMED && call_back); endproperty
    a_msg_end: assert property (p_msg_end) else $error("message end not completed");
endmodule : pcs_sequencer

/* File: sim/pcs_card_feeder.sv */
// Card reader stand-in feeding columns to the sequencer
`timescale 1ns/1ps
module pcs_card_feeder (
    input  wire logic   aclk,
    input  wire logic   reader_run,
    output logic        card_col_valid,
    output logic [11:0] card_col,
    output logic        card_end,
    output logic        hopper_empty
);
    logic [11:0] cols [8];
    int          ncol = 0;
    int          cnt = 0;
    logic        empty = 1'b0;
    logic        hit;
    assign hit = reader_run && cnt >= 4 && cnt < 4 + ncol;
    assign hopper_empty = empty;
    initial begin
        card_col = 12'h000;
        card_col_valid = 1'b0;
        card_end = 1'b0;
    end
    always @(posedge aclk) begin
        cnt <= reader_run ? cnt + 1 : 0;
        card_col_valid <= hit;
        // Released lines flip so a stale column never passes for data
        card_col <= hit ? cols[cnt-4] : ~card_col;
        card_end <= reader_run && cnt == 80;
    end
endmodule : pcs_card_feeder

/* File: sim/testbench.sv */
// Self-checking bench for the peripheral command sequencer
`timescale 1ns/1ps
module testbench;
    import pcs_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, trunk_lockout = 1'b0, punch_row_req = 1'b0, drum_bit_tick = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [7:0]  trunk_ack = 8'h00, trunk_addressees;
    logic        punch_last_row = 1'b0, punch_fire, trunk_valid, trunk_eom;
    logic [79:0] punch_row;
    logic [29:0] trunk_word;
    logic        awready, wready, bvalid, arready, rvalid, command_accept_pulse, priority_flag, call_back;
    logic        reader_run, card_col_valid, card_end, hopper_empty;
    logic [11:0] card_col;
    logic [1:0]  rresp, bresp, wr_resp;
    int          errors = 0, compares = 0, accepts = 0;
    always #12.5 aclk = ~aclk;
    always @(posedge aclk) if (command_accept_pulse === 1'b1) accepts <= accepts + 1;
    pcs_card_feeder u_rdr (.aclk, .reader_run, .card_col_valid, .card_col, .card_end, .hopper_empty);
    pcs_sequencer #(.RESP_CYCLES(8)) u_dut (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp,
        .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .command_accept_pulse, .priority_flag, .call_back, .reader_run, .card_col_valid, .card_col,
        .card_end, .hopper_empty, .punch_run(), .punch_row_req, .punch_last_row, .punch_fire,
        .punch_row, .drum_run(), .drum_track_sector(), .drum_bit_tick, .drum_wbit(), .drum_wen(),
        .drum_rbit(1'b0), .drum_block_end(1'b0), .trunk_word, .trunk_valid, .trunk_eom,
        .trunk_addressees, .trunk_ack, .trunk_lockout
    );
    task automatic axw(input logic [4:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        wr_resp = bresp;
        bready <= 1'b0;
    endtask : axw
    task automatic axr(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axr
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Shared card cycle; status nibble is {done, busy, eof, data error}
    task automatic card_read(input logic [2:0] op, input logic [29:0] word, input logic [3:0] st);
        logic [31:0] d;
        logic [1:0]  r;
        int          a0;
        a0 = accepts;
        axw(OFF_OP, {29'h0, op});
        chk("write response", {30'h0, RESP_OKAY}, {30'h0, wr_resp});
        repeat (3) @(posedge aclk);
        chk("accept", 32'(a0 + 1), 32'(accepts));
        chk("busy", 32'h1, {31'h0, reader_run});
        axw(OFF_OP, {29'h0, OP_TEXT});
        repeat (3) @(posedge aclk);
        chk("accept while busy", 32'(a0 + 1), 32'(accepts));
        while (priority_flag !== 1'b1) @(posedge aclk);
        axr(OFF_IN, d, r);
        chk("card word", {2'b00, word}, d);
        do @(posedge aclk); while (call_back !== 1'b1);
        chk("reader stopped", 32'h0, {31'h0, reader_run});
        while (priority_flag !== 1'b1) @(posedge aclk);
        axr(OFF_IN, d, r);
        chk("status", {28'h0, st}, {28'h0, d[ST_DONE], d[ST_BUSY], d[ST_EOF], d[ST_DERR]});
        repeat (3) @(posedge aclk);
        chk("accept on status", 32'(a0 + 2), 32'(accepts));
    endtask : card_read
    task automatic t_text;
        u_rdr.cols = '{12'h900, 12'h480, 12'h240, 12'h020, 12'h810, 12'h000, 12'h000, 12'h000};
        u_rdr.ncol = 5;
        card_read(OP_TEXT, {6'h31, 6'h22, 6'h13, 6'h04, 6'h35}, 4'b1000);
        $display("test text_read done");
    endtask : t_text
    task automatic t_image;
        // Row 9 of the third column is punched, so the dropped bits flag an error
        u_rdr.cols = '{12'h801, 12'h0f0, 12'h3c1, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000};
        u_rdr.ncol = 3;
        u_rdr.empty = 1'b1;
        card_read(OP_IMG, {12'h801, 12'h0f0, 6'h0f}, 4'b1011);
        $display("test image_read done");
    endtask : t_image
    task automatic t_refuse;
        logic [31:0] d;
        logic [1:0]  r;
        int          a0;
        a0 = accepts;
        trunk_lockout <= 1'b1;
        axw(OFF_OP, {29'h0, OP_MSG});
        repeat (3) @(posedge aclk);
        chk("accept under lockout", 32'(a0), 32'(accepts));
        trunk_lockout <= 1'b0;
        axr(5'h1c, d, r);
        chk("unmapped response", {30'h0, RESP_SLVERR}, {30'h0, r});
        axw(5'h1c, 32'h0);
        chk("unmapped write response", {30'h0, RESP_SLVERR}, {30'h0, wr_resp});
        $display("test refusals done");
    endtask : t_refuse
    task automatic t_punch;
        logic [31:0] d;
        logic [1:0]  r;
        axw(OFF_OP, {29'h0, OP_PUNCH});
        // First row is due before any data, so it must count as late
        punch_row_req <= 1'b1;
        @(posedge aclk);
        punch_row_req <= 1'b0;
        axw(OFF_CODE, {29'h0, C_M1});
        axw(OFF_OUT, 32'h1);
        axw(OFF_CODE, {29'h0, C_P3});
        axw(OFF_OUT, 32'h80000);
        punch_row_req <= 1'b1;
        punch_last_row <= 1'b1;
        @(posedge aclk);
        punch_row_req <= 1'b0;
        punch_last_row <= 1'b0;
        @(posedge aclk);
        chk("punch fire", 32'h1, {31'h0, punch_fire});
        chk("punch cols 1-32", 32'h1, punch_row[31:0]);
        chk("punch cols 49-80", 32'h8000_0000, punch_row[79:48]);
        chk("punch call-back", 32'h1, {31'h0, call_back});
        axr(OFF_IN, d, r);
        chk("punch status", 32'h5, {29'h0, d[ST_DONE], d[ST_BUSY], d[ST_TERR]});
        $display("test card_punch done");
    endtask : t_punch
    task automatic t_msg;
        int a0;
        axw(OFF_ARG, 32'h6);
        a0 = accepts;
        axw(OFF_OP, {29'h0, OP_MSG});
        axw(OFF_FLAG, 32'h1);
        axw(OFF_CODE, {29'h0, C_P1});
        axw(OFF_OUT, 32'h2a);
        // Acknowledges arrive one addressee at a time
        trunk_ack <= 8'h01;
        @(posedge aclk);
        trunk_ack <= 8'h02;
        chk("trunk word", 32'h2a, 32'(trunk_word));
        chk("trunk eom and addressees", 32'h103, {23'h0, trunk_eom, trunk_addressees});
        @(posedge aclk);
        trunk_ack <= 8'h00;
        chk("trunk repeat", 32'h1, {31'h0, trunk_valid});
        @(posedge aclk);
        chk("trunk released", 32'h0, {31'h0, trunk_valid});
        chk("message call-back", 32'h1, {31'h0, call_back});
        chk("message accepts", 32'(a0 + 2), 32'(accepts));
        $display("test message done");
    endtask : t_msg
    task automatic complete_run;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_text;
        t_image;
        t_refuse;
        t_punch;
        t_msg;
        complete_run;
    end
    // Five short scenarios need well under a thousand cycles
    initial begin
        #125000;
        errors++;
        $display("unexpected watchdog: expected finish seen hang");
        complete_run;
    end
endmodule : testbench
